// File: hdl/rsc_freq_check.sv
// Purpose: scale a frequency argument to micro-hertz, range check and apply resolution
// Assumes: start is a one-cycle pulse; result follows on the next edge
// Notes: above the fine band the value is truncated to whole milli-hertz
`timescale 1ns/1ps
module rsc_freq_check (
	input wire logic ref_clk_i,                                   // 20 MHz clock
	input wire logic srst_i,                                      // sync reset, high
	input wire logic start_i,                                     // check request
	input wire logic [rsc_pkg::ARG_W-1:0] value_i,                // micro-units of suffix
	input wire rsc_pkg::rsc_suffix_t suffix_i,                    // unit suffix
	output logic done_o,                                          // result pulse
	output logic ok_o,                                            // value accepted
	output logic [rsc_pkg::FREQ_W-1:0] freq_o                     // micro-hertz
);

	logic done_q, done_d, ok_q, ok_d;
	logic [rsc_pkg::FREQ_W-1:0] freq_q, freq_d;
	logic [rsc_pkg::SCALE_W-1:0] scale;
	logic [rsc_pkg::PROD_W-1:0] prod;
	logic [rsc_pkg::FREQ_W-1:0] raw;

	// scale, range and resolution
	always_comb begin
		unique case (suffix_i)
			rsc_pkg::SFX_KHZ: scale = rsc_pkg::SCALE_KHZ;
			rsc_pkg::SFX_MHZ: scale = rsc_pkg::SCALE_MHZ;
			default: scale = rsc_pkg::SCALE_HZ;  // bare number means hertz
		endcase
		prod = rsc_pkg::PROD_W'(value_i) * rsc_pkg::PROD_W'(scale);
		raw = prod[rsc_pkg::FREQ_W-1:0];
		done_d = start_i;
		ok_d = ok_q;
		freq_d = freq_q;
		if (start_i) begin
			ok_d = (prod <= rsc_pkg::FREQ_MAX_UHZ); // RQ15
			if (raw < rsc_pkg::FINE_LIMIT_UHZ) begin
				freq_d = raw; // RQ15
			end else begin
				freq_d = raw - (raw % rsc_pkg::COARSE_STEP_UHZ); // RQ15
			end
		end
	end

	// result registers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			done_q <= 1'b0;
			ok_q <= 1'b0;
			freq_q <= '0;
		end else begin
			done_q <= done_d;
			ok_q <= ok_d;
			freq_q <= freq_d;
		end
	end

	assign done_o = done_q;
	assign ok_o = ok_q;
	assign freq_o = freq_q;

endmodule

// File: hdl/rsc_pkg.sv
// Purpose: shared types and constants for the remote status and command decoder
// Assumes: commands arrive already tokenised by an upstream bus front end
// Notes: frequency values are carried in micro-units of the given suffix
package rsc_pkg;

	// status byte bit positions
	localparam int unsigned SB_PROG_ERR = 0;
	localparam int unsigned SB_SWEEP_END = 1;
	localparam int unsigned SB_SWEEP_RUN = 2;
	localparam int unsigned SB_HW_FAULT = 3;
	localparam int unsigned SB_READY = 4;
	localparam int unsigned SB_ERR_SUM = 5;
	localparam int unsigned SB_RQS = 6;
	localparam int unsigned SB_POWER = 7;

	// widths
	localparam int unsigned ARG_W = 48;
	localparam int unsigned FREQ_W = 44;
	localparam int unsigned SCALE_W = 20;
	localparam int unsigned PROD_W = ARG_W + SCALE_W;

	// reset values and the byte argument limit
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [5:0] MOD_RST = 6'h00;
	localparam logic [7:0] BYTE_MAX = 8'hFF;

	// error codes reported by the error-number query (arbitrary values)
	localparam logic [7:0] ERR_PARAM = 8'h01;
	localparam logic [7:0] ERR_FREQ = 8'h02;
	localparam logic [7:0] ERR_UNKNOWN = 8'h03;

	// suffix scale factors to micro-hertz
	localparam logic [SCALE_W-1:0] SCALE_HZ = 20'h00001;
	localparam logic [SCALE_W-1:0] SCALE_KHZ = 20'h003E8;
	localparam logic [SCALE_W-1:0] SCALE_MHZ = 20'hF4240;

	// frequency limits in micro-hertz
	localparam logic [PROD_W-1:0] FREQ_MAX_UHZ = 68'h0_0000_0BD2_CC61_D000;  // 13 MHz
	localparam logic [FREQ_W-1:0] FINE_LIMIT_UHZ = 44'h017_4876_E800;      // 100 kHz
	localparam logic [FREQ_W-1:0] COARSE_STEP_UHZ = 44'h000_0000_03E8;     // 1 mHz

	typedef enum logic [2:0] {
		OP_MOD_EN = 3'b000,
		OP_FREQ = 3'b001,
		OP_MASK = 3'b010,
		OP_ERR_QUERY = 3'b011,
		OP_OTHER = 3'b100
	} rsc_op_t;

	typedef enum logic [1:0] {
		SFX_HZ = 2'b00,
		SFX_KHZ = 2'b01,
		SFX_MHZ = 2'b10,
		SFX_NONE = 2'b11
	} rsc_suffix_t;

	typedef enum logic [1:0] {
		KW_NONE = 2'b00,
		KW_OFF = 2'b01,
		KW_ON = 2'b10,
		KW_BAD = 2'b11
	} rsc_keyword_t;

	// modulation enable selectors (index into the enable vector)
	localparam logic [2:0] MOD_A_EXT_AM = 3'h0;
	localparam logic [2:0] MOD_A_EXT_PM = 3'h1;
	localparam logic [2:0] MOD_A_INT_AM = 3'h2;
	localparam logic [2:0] MOD_A_INT_PM = 3'h3;
	localparam logic [2:0] MOD_B_EXT_AM = 3'h4;
	localparam logic [2:0] MOD_B_EXT_PM = 3'h5;
	localparam int unsigned MOD_N = 6;

	typedef struct packed {
		rsc_op_t op;
		logic [2:0] sel;
		rsc_keyword_t keyword;
		logic [ARG_W-1:0] value;
		rsc_suffix_t suffix;
	} rsc_cmd_t;

endpackage

// File: hdl/rsc_remote_ctrl.sv
// Purpose: status byte, service request, device clear, error query and command decode
// Assumes: tokenised commands, poll and clear strobes come from logic on ref_clk_i
// Notes: commands are taken only while cmd_ready_o is high
`timescale 1ns/1ps

// Functional notes
// RQ1 - status bit 5 (weight 32) is high whenever a programming or hardware error exists
// RQ2 - with mask 32 only the error summary bit can raise a service request
// RQ3 - mask argument is a weight sum; exactly those status bits may request service
// RQ4 - selective device clear empties the status byte and drops any service request; bits 2 to 5 still follow sweep, fault and ready
// RQ5 - polled status byte carries bit 6 while service is requested
// RQ6 - a programming error sets status bit 0
// RQ7 - a completed sweep sets status bit 1
// RQ8 - a running sweep shows as status bit 2
// RQ9 - a hardware fault sets status bit 3
// RQ10 - status bit 4 shows readiness to accept more bus data
// RQ11 - power-on or power failure sets status bit 7
// RQ12 - out-of-range arguments flag an error and may request service via the mask
// RQ13 - error query answers with one code, that of the pending error
// RQ14 - modulation enables take 0, 1, OFF or ON; 1 and ON enable
// RQ15 - center frequency 0 to 13 MHz, HZ/KILOHERTZ_SUFFIX/MEGAHERTZ_SUFFIX, 1 uHz below 100 kHz else 1 mHz
// RQ16 - every poll returns this device's own status byte
// RQ17 - a poll that reads the request bit clears it and drops the request
module rsc_remote_ctrl (
	input wire logic ref_clk_i,                       // 20 MHz clock
	input wire logic srst_i,                          // sync reset, high
	input wire logic cmd_valid_i,                     // command strobe
	input wire rsc_pkg::rsc_cmd_t cmd_i,              // tokenised command
	input wire logic spoll_i,                         // serial poll strobe
	input wire logic dev_clear_i,                     // selective device clear strobe
	input wire logic sweep_done_i,                    // sweep completed pulse
	input wire logic sweep_running_i,                 // sweep active level
	input wire logic hw_fault_i,                      // hardware fault level
	input wire logic power_event_i,                   // power failure pulse
	output logic cmd_ready_o,                         // can take a command
	output logic [7:0] status_byte_o,                 // live status byte
	output logic [7:0] poll_byte_o,                   // byte answered to a poll
	output logic poll_valid_o,                        // poll answer pulse
	output logic srq_o,                               // service request line
	output logic [7:0] err_code_o,                    // error query answer
	output logic err_valid_o,                         // error answer pulse
	output logic [rsc_pkg::MOD_N-1:0] mod_enable_o,   // modulation enables
	output logic [rsc_pkg::FREQ_W-1:0] center_freq_o  // center frequency, uHz
);

	// idle takes commands; freq waits for the range check to answer
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_FREQ = 1'b1
	} rsc_state_t;

	// registered state with next values
	rsc_state_t state_q, state_d;
	logic [7:0] mask_q, mask_d;
	logic [7:0] err_q, err_d;
	logic prog_err_q, prog_err_d;
	logic sweep_end_q, sweep_end_d;
	logic power_q, power_d;
	logic rqs_q, rqs_d;
	logic sum_q, sum_d;
	logic ready_q, ready_d;
	logic [7:0] status_q, status_d;
	logic [7:0] poll_byte_q, poll_byte_d;
	logic poll_valid_q, poll_valid_d;
	logic [7:0] err_out_q, err_out_d;
	logic err_valid_q, err_valid_d;
	logic [rsc_pkg::MOD_N-1:0] mod_q, mod_d;
	logic [rsc_pkg::FREQ_W-1:0] cf_q, cf_d;
	// frequency checker handshake
	logic chk_start, chk_done, chk_ok;
	logic [rsc_pkg::FREQ_W-1:0] chk_freq;
	// decode to status hand-over
	logic set_err, clr_err;
	logic [7:0] new_err;
	logic [7:0] cond;
	logic take;

	// decode an on/off argument: bit 1 is legal, bit 0 is the value
	// numbers other than 0 and 1 and a bad keyword come back as illegal
	function automatic logic [1:0] onoff(input rsc_pkg::rsc_keyword_t kw,
		input logic [rsc_pkg::ARG_W-1:0] val);
		logic [1:0] r;
		r = 2'b00;
		unique case (kw)
			rsc_pkg::KW_ON: r = 2'b11;
			rsc_pkg::KW_OFF: r = 2'b10;
			rsc_pkg::KW_NONE: begin
				if (val == '0) begin
					r = 2'b10;
				end else if (val == rsc_pkg::ARG_W'(1)) begin
					r = 2'b11;
				end
			end
			rsc_pkg::KW_BAD: r = 2'b00;
		endcase
		return r;
	endfunction

	// range check and resolution of the frequency argument, one edge after start;
	// the command lines only stand in the taking cycle, so the checker latches there
	rsc_freq_check u_freq_check (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.start_i(chk_start),
		.value_i(cmd_i.value),
		.suffix_i(cmd_i.suffix),
		.done_o(chk_done),
		.ok_o(chk_ok),
		.freq_o(chk_freq)
	);

	// a command is taken only while ready; anything else is dropped silently
	assign take = cmd_valid_i && ready_q;

	// command decode and settings
	always_comb begin
		logic [1:0] oo;
		oo = onoff(cmd_i.keyword, cmd_i.value);
		state_d = state_q;
		mask_d = mask_q;
		mod_d = mod_q;
		cf_d = cf_q;
		chk_start = 1'b0;
		set_err = 1'b0;
		new_err = rsc_pkg::ERR_NONE;
		err_out_d = err_out_q;
		err_valid_d = 1'b0;
		clr_err = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (take) begin
					unique case (cmd_i.op)
						// a bad selector or argument leaves the enables untouched
						rsc_pkg::OP_MOD_EN: begin
							if (oo[1] && (cmd_i.sel < 3'(rsc_pkg::MOD_N))) begin
								mod_d[cmd_i.sel] = oo[0]; // RQ14
							end else begin
								set_err = 1'b1; // RQ12
								new_err = rsc_pkg::ERR_PARAM;
							end
						end
						// the range check takes a cycle; ready stays low meanwhile
						rsc_pkg::OP_FREQ: begin
							chk_start = 1'b1;
							state_d = ST_FREQ;
						end
						// mask bit 6 has no condition behind it, so it never requests
						rsc_pkg::OP_MASK: begin
							if (cmd_i.value <= rsc_pkg::ARG_W'(rsc_pkg::BYTE_MAX)) begin
								mask_d = cmd_i.value[7:0]; // RQ3
							end else begin
								set_err = 1'b1; // RQ12
								new_err = rsc_pkg::ERR_PARAM;
							end
						end
						// answer with the pending code; a new error this cycle still wins
						rsc_pkg::OP_ERR_QUERY: begin
							err_out_d = err_q; // RQ13
							err_valid_d = 1'b1;
							clr_err = 1'b1;
						end
						// unused operation codes are refused as unknown
						default: begin
							set_err = 1'b1;
							new_err = rsc_pkg::ERR_UNKNOWN;
						end
					endcase
				end
			end
			// the new value or an error lands together with the return to idle
			ST_FREQ: begin
				if (chk_done) begin
					state_d = ST_IDLE;
					if (chk_ok) begin
						cf_d = chk_freq; // RQ15
					end else begin
						set_err = 1'b1; // RQ12
						new_err = rsc_pkg::ERR_FREQ;
					end
				end
			end
		endcase
	end

	// decode registers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_q <= ST_IDLE;
			mask_q <= rsc_pkg::MASK_RST;
			mod_q <= rsc_pkg::MOD_RST;
			cf_q <= '0;
			err_out_q <= rsc_pkg::ERR_NONE;
			err_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			mask_q <= mask_d;
			mod_q <= mod_d;
			cf_q <= cf_d;
			err_out_q <= err_out_d;
			err_valid_q <= err_valid_d;
		end
	end

	// sticky flag: hold until cleared; a set in the same cycle as a clear wins,
	// so an event that lands on a clear or a poll is never lost
	function automatic logic sticky(input logic set_now, input logic held,
		input logic clr_now);
		return set_now | (held & ~clr_now);
	endfunction

	// error record and sticky events; the error query and a device clear both empty
	// the pending code, a new error in the same cycle replaces it instead
	always_comb begin
		prog_err_d = sticky(set_err, prog_err_q, clr_err | dev_clear_i); // RQ6 RQ4
		if (set_err) begin
			err_d = new_err;
		end else if (clr_err || dev_clear_i) begin
			err_d = rsc_pkg::ERR_NONE;
		end else begin
			err_d = err_q;
		end
		sweep_end_d = sticky(sweep_done_i, sweep_end_q, dev_clear_i); // RQ7 RQ4
		power_d = sticky(power_event_i, power_q, dev_clear_i); // RQ11 RQ4
	end

	// error and event registers; power-on marks the power bit
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			prog_err_q <= 1'b0;
			err_q <= rsc_pkg::ERR_NONE;
			sweep_end_q <= 1'b0;
			power_q <= 1'b1; // RQ11
		end else begin
			prog_err_q <= prog_err_d;
			err_q <= err_d;
			sweep_end_q <= sweep_end_d;
			power_q <= power_d;
		end
	end

	// condition bits and service request; only a rise of the masked summary raises
	// the request, so a condition that stays set cannot re-raise it after a poll
	always_comb begin
		ready_d = (state_d == ST_IDLE); // RQ10
		cond = 8'h00;
		cond[rsc_pkg::SB_PROG_ERR] = prog_err_q; // RQ6
		cond[rsc_pkg::SB_SWEEP_END] = sweep_end_q; // RQ7
		cond[rsc_pkg::SB_SWEEP_RUN] = sweep_running_i; // RQ8
		cond[rsc_pkg::SB_HW_FAULT] = hw_fault_i; // RQ9
		cond[rsc_pkg::SB_READY] = ready_q; // RQ10
		cond[rsc_pkg::SB_ERR_SUM] = prog_err_q | hw_fault_i; // RQ1
		cond[rsc_pkg::SB_POWER] = power_q; // RQ11
		sum_d = |(cond & mask_q); // RQ2 RQ3
		rqs_d = sticky(sum_d & ~sum_q, rqs_q, dev_clear_i | spoll_i); // RQ4 RQ17 RQ12
		status_d = cond;
		status_d[rsc_pkg::SB_RQS] = rqs_d;
	end

	// status and request registers; ready is high out of reset
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ready_q <= 1'b1;
			sum_q <= 1'b0;
			rqs_q <= 1'b0;
			status_q <= 8'h00;
		end else begin
			ready_q <= ready_d;
			sum_q <= sum_d;
			rqs_q <= rqs_d;
			status_q <= status_d;
		end
	end

	// poll answer; the request bit is the one seen before this poll drops it,
	// and the byte holds until the next poll
	always_comb begin
		poll_byte_d = poll_byte_q;
		poll_valid_d = 1'b0;
		if (spoll_i) begin
			poll_byte_d = cond; // RQ16
			poll_byte_d[rsc_pkg::SB_RQS] = rqs_q; // RQ5
			poll_valid_d = 1'b1;
		end
	end

	// poll answer registers
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			poll_byte_q <= 8'h00;
			poll_valid_q <= 1'b0;
		end else begin
			poll_byte_q <= poll_byte_d;
			poll_valid_q <= poll_valid_d;
		end
	end

	// every output comes straight from a register, so the bus side never
	// sees a combinational glitch
	assign cmd_ready_o = ready_q;
	assign status_byte_o = status_q;
	assign poll_byte_o = poll_byte_q;
	assign poll_valid_o = poll_valid_q;
	assign srq_o = rqs_q; // RQ2
	assign err_code_o = err_out_q;
	assign err_valid_o = err_valid_q;
	assign mod_enable_o = mod_q;
	assign center_freq_o = cf_q;

endmodule

// File: verification/rsc_bus_ctl.sv
// Purpose: behavioural bus controller issuing commands, polls and clears
// Assumes: tasks are entered 2 ns after a rising edge
// Notes: command lines are scrambled once a command is taken
`timescale 1ns/1ps
module rsc_bus_ctl (
	input wire logic ref_clk_i, // clock
	input wire logic cmd_ready_i, // device ready
	input wire logic err_valid_i, // error answer pulse
	input wire logic [7:0] err_code_i, // error answer
	input wire logic poll_valid_i, // poll answer pulse
	input wire logic [7:0] poll_byte_i, // polled byte
	output logic cmd_valid_o, // command strobe
	output rsc_pkg::rsc_cmd_t cmd_o, // command
	output logic spoll_o, // poll strobe
	output logic dev_clear_o // clear strobe
);
	// idle lines
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
		spoll_o = 1'b0;
		dev_clear_o = 1'b0;
	end
	// hold a command until taken, then read the one answer
	task automatic send(input rsc_pkg::rsc_cmd_t c, output logic v, output logic [7:0] e);
		cmd_o = c;
		cmd_valid_o = 1'b1;
		while (cmd_ready_i !== 1'b1) @(posedge ref_clk_i) #2;
		@(posedge ref_clk_i);
		#2;
		cmd_valid_o = 1'b0;
		cmd_o = ~c;
		v = err_valid_i;
		e = err_code_i;
		@(posedge ref_clk_i);
		#2;
	endtask
	// serial poll of this one device
	task automatic poll(output logic v, output logic [7:0] b);
		spoll_o = 1'b1;
		@(posedge ref_clk_i);
		#2;
		spoll_o = 1'b0;
		v = poll_valid_i;
		b = poll_byte_i;
		@(posedge ref_clk_i);
		#2;
	endtask
	// selective device clear
	task automatic clear();
		dev_clear_o = 1'b1;
		@(posedge ref_clk_i);
		#2;
		dev_clear_o = 1'b0;
		@(posedge ref_clk_i);
		#2;
	endtask
endmodule

// File: verification/rsc_remote_ctrl_monitor.sv
// Purpose: port level assertions for the remote status and command decoder
// Assumes: one clock domain, synchronous active high reset
// Notes: bound to the decoder from the bench top file
`timescale 1ns/1ps
module rsc_remote_ctrl_chk (
	input wire logic ref_clk_i, // clock
	input wire logic srst_i, // reset
	input wire logic cmd_valid_i, // command strobe
	input wire rsc_pkg::rsc_cmd_t cmd_i, // command
	input wire logic spoll_i, // poll strobe
	input wire logic dev_clear_i, // clear strobe
	input wire logic sweep_running_i, // running level
	input wire logic hw_fault_i, // fault level
	input wire logic cmd_ready_o, // ready
	input wire logic [7:0] status_byte_o, // status
	input wire logic [7:0] poll_byte_o, // polled byte
	input wire logic poll_valid_o, // poll pulse
	input wire logic srq_o, // request line
	input wire logic err_valid_o // error pulse
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// accepted commands by kind
	logic take_err;
	logic take_frq;
	assign take_err = cmd_valid_i && cmd_ready_o && cmd_i.op == rsc_pkg::OP_ERR_QUERY;
	assign take_frq = cmd_valid_i && cmd_ready_o && cmd_i.op == rsc_pkg::OP_FREQ;
	AST_ERR_SUM: assert property (status_byte_o[5] == (status_byte_o[0] | status_byte_o[3]))
		else $error("error summary bit wrong");
	AST_SRQ_HOLD: assert property (srq_o && !spoll_i && !dev_clear_i |=> srq_o)
		else $error("request dropped without poll or clear");
	AST_CLEAR: assert property (dev_clear_i |=> !srq_o)
		else $error("request survived device clear");
	AST_POLL_RQS: assert property (spoll_i |=> poll_valid_o && poll_byte_o[6] == $past(srq_o))
		else $error("polled request bit wrong");
	AST_RUN: assert property (!$past(srst_i) |-> status_byte_o[2] == $past(sweep_running_i))
		else $error("running bit does not follow sweep");
	AST_FAULT: assert property (!$past(srst_i) |-> status_byte_o[3] == $past(hw_fault_i))
		else $error("fault bit does not follow fault");
	AST_ERR_ANS: assert property (take_err |=> err_valid_o)
		else $error("no answer to error query");
	AST_FREQ_BUSY: assert property (take_frq |=> !cmd_ready_o ##1 cmd_ready_o)
		else $error("frequency command busy time wrong");
	AST_POLL_DROP: assert property (spoll_i |=> !srq_o)
		else $error("request not dropped by poll");
	// main scenarios
	cover property (take_frq);
	cover property ($rose(srq_o));
	cover property (spoll_i && srq_o);
endmodule

// File: verification/tb.sv
// Purpose: self checking bench for the remote status and command decoder
// Assumes: inputs change 2 ns after the rising edge
// Notes: status, poll, error and setting outputs are compared with a small model
`timescale 1ns/1ps
module tb;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic sweep_done_i = 1'b0;
	logic sweep_running_i = 1'b0;
	logic hw_fault_i = 1'b0;
	logic power_event_i = 1'b0;
	logic cmd_valid_i, spoll_i, dev_clear_i, cmd_ready_o, poll_valid_o, srq_o, err_valid_o, v;
	rsc_pkg::rsc_cmd_t cmd_i;
	logic [7:0] status_byte_o, poll_byte_o, err_code_o, b;
	logic [rsc_pkg::MOD_N-1:0] mod_enable_o;
	logic [rsc_pkg::FREQ_W-1:0] center_freq_o;
	logic [5:0] mods = '0;
	int n_mismatch = 0, num_checks = 0, cyc = 0, perr = 0, sdone = 0, pwr = 1, srqm = 0;
	longint unsigned f, u;
	always #25 ref_clk_i = ~ref_clk_i;
	rsc_remote_ctrl i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .spoll_i(spoll_i), .dev_clear_i(dev_clear_i), .sweep_done_i(sweep_done_i),
		.sweep_running_i(sweep_running_i), .hw_fault_i(hw_fault_i), .power_event_i(power_event_i),
		.cmd_ready_o(cmd_ready_o), .status_byte_o(status_byte_o), .poll_byte_o(poll_byte_o),
		.poll_valid_o(poll_valid_o), .srq_o(srq_o), .err_code_o(err_code_o),
		.err_valid_o(err_valid_o), .mod_enable_o(mod_enable_o), .center_freq_o(center_freq_o));
	rsc_bus_ctl i_ctl (.ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready_o), .err_valid_i(err_valid_o),
		.err_code_i(err_code_o), .poll_valid_i(poll_valid_o), .poll_byte_i(poll_byte_o),
		.cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .spoll_o(spoll_i), .dev_clear_o(dev_clear_i));
	// compare and count
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// expected status byte
	function automatic logic [7:0] est();
		return {pwr[0], srqm[0], perr[0] | hw_fault_i, 1'b1, hw_fault_i, sweep_running_i,
			sdone[0], perr[0]};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask
	task automatic mk(input rsc_pkg::rsc_op_t o, input logic [2:0] s, input logic [1:0] k,
		input logic [47:0] val, input logic [1:0] x);
		i_ctl.send(rsc_pkg::rsc_cmd_t'{o, s, rsc_pkg::rsc_keyword_t'(k), val,
			rsc_pkg::rsc_suffix_t'(x)}, v, b);
	endtask
	task automatic pulse_done();
		sweep_done_i = 1'b1;
		wt(1);
		sweep_done_i = 1'b0;
		sdone = 1;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	// main sequence
	initial begin
		int k;
		void'($urandom(40));
		sweep_running_i = 1'($urandom_range(1, 0));
		repeat (12) @(posedge ref_clk_i);
		#2 srst_i = 1'b0;
		wt(2);
		chk("status", est(), status_byte_o);
		$display("test reset done");
		for (int i = 0; i < 18; i++) begin
			k = $urandom_range(3, 0);
			mk(rsc_pkg::OP_MOD_EN, 3'(i % 6), 2'(k < 2 ? 0 : k - 1), 48'(k < 2 ? k : 0), 2'h3);
			mods[i % 6] = k[0];
			chk("mod", mods, mod_enable_o);
		end
		mk(rsc_pkg::OP_MOD_EN, 3'h0, 2'h0, 48'h2, 2'h3);
		perr = 1;
		wt(2);
		chk("status", est(), status_byte_o);
		mk(rsc_pkg::OP_ERR_QUERY, 3'h0, 2'h0, 48'h0, 2'h3);
		chk("err", {1'b1, rsc_pkg::ERR_PARAM}, {v, b});
		perr = 0;
		mk(rsc_pkg::OP_OTHER, 3'h0, 2'h0, 48'h0, 2'h3);
		mk(rsc_pkg::OP_ERR_QUERY, 3'h0, 2'h0, 48'h0, 2'h3);
		chk("err", {1'b1, rsc_pkg::ERR_UNKNOWN}, {v, b});
		mk(rsc_pkg::OP_MASK, 3'h0, 2'h0, 48'h100, 2'h3);
		mk(rsc_pkg::OP_MOD_EN, 3'h1, 2'h3, 48'h1, 2'h3);
		mk(rsc_pkg::OP_MOD_EN, 3'h7, 2'h2, 48'h0, 2'h3);
		mk(rsc_pkg::OP_ERR_QUERY, 3'h0, 2'h0, 48'h0, 2'h3);
		chk("err", {1'b1, rsc_pkg::ERR_PARAM}, {v, b});
		chk("mod", mods, mod_enable_o);
		$display("test modulation done");
		mk(rsc_pkg::OP_MASK, 3'h0, 2'h0, 48'h20, 2'h3);
		pulse_done();
		wt(2);
		chk("status", est(), status_byte_o);
		mk(rsc_pkg::OP_FREQ, 3'h0, 2'h0, 48'd14000000, 2'h2);
		perr = 1;
		srqm = 1;
		wt(3);
		chk("status", est(), status_byte_o);
		i_ctl.poll(v, b);
		chk("poll", {1'b1, est()}, {v, b});
		srqm = 0;
		chk("srq", 0, srq_o);
		mk(rsc_pkg::OP_ERR_QUERY, 3'h0, 2'h0, 48'h0, 2'h3);
		chk("err", {1'b1, rsc_pkg::ERR_FREQ}, {v, b});
		perr = 0;
		$display("test request done");
		for (int i = 0; i < 4; i++) begin
			if (i == 0) f = 64'h2E_90ED_D000 + $urandom_range(999, 0);
			else if (i == 1) f = $urandom_range(99999999, 0);
			else if (i == 2) f = 13000000;
			else f = $urandom;
			mk(rsc_pkg::OP_FREQ, 3'h0, 2'h0, 48'(f), 2'(i));
			u = f * (i == 1 ? 1000 : i == 2 ? 1000000 : 1);
			if (u >= rsc_pkg::FINE_LIMIT_UHZ) u -= u % rsc_pkg::COARSE_STEP_UHZ;
			wt(1);
			chk("freq", u, center_freq_o);
		end
		$display("test frequency done");
		hw_fault_i = 1'b1;
		srqm = 1;
		wt(3);
		chk("status", est(), status_byte_o);
		hw_fault_i = 1'b0;
		wt(2);
		chk("status", est(), status_byte_o);
		i_ctl.clear();
		{srqm, sdone, pwr} = '0;
		wt(2);
		chk("status", est(), status_byte_o);
		mk(rsc_pkg::OP_MASK, 3'h0, 2'h0, 48'h2, 2'h3);
		pulse_done();
		srqm = 1;
		wt(3);
		chk("status", est(), status_byte_o);
		power_event_i = 1'b1;
		wt(1);
		power_event_i = 1'b0;
		pwr = 1;
		wt(2);
		chk("status", est(), status_byte_o);
		$display("test clear done");
		test_done();
	end
endmodule
bind rsc_remote_ctrl rsc_remote_ctrl_chk i_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .spoll_i(spoll_i), .dev_clear_i(dev_clear_i),
	.sweep_running_i(sweep_running_i), .hw_fault_i(hw_fault_i), .cmd_ready_o(cmd_ready_o),
	.status_byte_o(status_byte_o), .poll_byte_o(poll_byte_o), .poll_valid_o(poll_valid_o),
	.srq_o(srq_o), .err_valid_o(err_valid_o));
